/* design/irq_ctrl_map.svh */
// register addresses, reset values, bit positions and source indices of the interrupt controller
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

`define SFR_IE_ADDR 8'hA8
`define SFR_INTERRUPT_ENABLE_LEVEL_EXT_ADDR 8'hA9
`define SFR_IP_ADDR 8'hB8
`define SFR_WDCFG_ADDR 8'hC0
`define SFR_UNMAPPED_DATA 8'h00

`define IE_RESET 8'h00
`define INTERRUPT_ENABLE_LEVEL_EXT_RESET 8'hA0
`define IP_RESET 8'h00
`define WDCFG_RESET 8'h10

`define IE_GATE_BIT 7
`define IE_TEMP_BIT 6
`define IE_TIMER2_BIT 5
`define IE_UART_BIT 4
`define IE_TIMER1_BIT 3
`define IE_EXT1_BIT 2
`define IE_TIMER0_BIT 1
`define IE_EXT0_BIT 0

`define IP_METER_BIT 7
`define IP_TEMP_BIT 6
`define IP_TIMER2_BIT 5
`define IP_UART_BIT 4
`define IP_TIMER1_BIT 3
`define IP_EXT1_BIT 2
`define IP_TIMER0_BIT 1
`define IP_EXT0_BIT 0

`define INTERRUPT_ENABLE_LEVEL_EXT_RTC_LEVEL_BIT 6
`define INTERRUPT_ENABLE_LEVEL_EXT_SIF_LEVEL_BIT 4
`define INTERRUPT_ENABLE_LEVEL_EXT_METER_ON_BIT 3
`define INTERRUPT_ENABLE_LEVEL_EXT_RTC_ON_BIT 2
`define INTERRUPT_ENABLE_LEVEL_EXT_SUPPLY_ON_BIT 1
`define INTERRUPT_ENABLE_LEVEL_EXT_SIF_ON_BIT 0

`define WD_RESPONSE_BIT 3
`define WD_STATUS_BIT 2
`define WD_ENABLE_BIT 1
`define WD_WRITE_EN_BIT 0

`define SRC_COUNT 12
`define SRC_SUPPLY 0
`define SRC_EXT0 1
`define SRC_TIMER0 2
`define SRC_EXT1 3
`define SRC_TIMER1 4
`define SRC_UART 5
`define SRC_TIMER2 6
`define SRC_SERIAL_IF 7
`define SRC_METER 8
`define SRC_TEMP 9
`define SRC_RTC 10
`define SRC_WATCHDOG 11

`endif

/* design/irq_ctrl_pkg.sv */
// types shared by the interrupt controller files
package irq_ctrl_pkg;

  typedef enum logic [1:0] {level_low, level_high, level_top} irq_level_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_req_t;

  typedef struct packed {
    logic timer0;
    logic timer1;
    logic timer2;
    logic uart;
    logic serial_if;
    logic temp_adc;
    logic meter;
    logic rtc;
    logic supply_monitor;
  } irq_src_t;

  typedef struct packed {
    logic req;
    logic [3:0] vector;
    irq_level_t level;
  } irq_out_t;

  typedef struct packed {
    logic [7:0] ie;
    logic [7:0] interrupt_enable_level_ext;
    logic [7:0] ip;
    logic [7:0] wdcfg;
    logic wd_armed;
    logic [1:0] ext_sync1;
    logic [1:0] ext_sync2;
    logic [2:0] in_service;
    irq_out_t out;
    logic [7:0] rdata;
    logic wd_reset_pulse;
    logic wd_restart_pulse;
  } ctl_state_t;

endpackage : irq_ctrl_pkg

/* design/irq_poll_arbiter.sv */
// picks the winning pending source: highest level first, then fixed polling order
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_map.svh"

module irq_poll_arbiter (
  // gated pending requests and their levels
  input wire logic [`SRC_COUNT-1:0] pending,
  input wire logic [`SRC_COUNT-1:0] high_sel,
  input wire logic [`SRC_COUNT-1:0] top_sel,
  // winner
  output logic found,
  output logic [3:0] vector,
  output irq_ctrl_pkg::irq_level_t level
);

  logic [`SRC_COUNT-1:0] top_vec;
  logic [`SRC_COUNT-1:0] high_vec;
  logic [`SRC_COUNT-1:0] low_vec;

  // lowest index wins inside one level
  function automatic logic [3:0] first_index(input logic [`SRC_COUNT-1:0] vec);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = `SRC_COUNT - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_index

  always_comb begin
    top_vec = pending & top_sel;
    high_vec = pending & ~top_sel & high_sel;
    low_vec = pending & ~top_sel & ~high_sel;
    found = |pending;
    if (|top_vec) begin // [RULE_02]
      vector = first_index(top_vec);
      level = irq_ctrl_pkg::level_top;
    end else if (|high_vec) begin // [RULE_03]
      vector = first_index(high_vec); // [RULE_05] [RULE_06]
      level = irq_ctrl_pkg::level_high;
    end else begin
      vector = first_index(low_vec); // [RULE_05] [RULE_06]
      level = irq_ctrl_pkg::level_low;
    end
  end

endmodule : irq_poll_arbiter
`default_nettype wire

/* design/irq_controller.sv */
// three-level interrupt controller with its special function registers
// Functional notes
// (RULE_01) twelve interrupt sources are arbitrated over exactly three priority levels
// (RULE_02) supply monitor alone holds top level and pre-empts any running routine
// (RULE_03) high-level request pre-empts low routine; high wins simultaneous arrival
// (RULE_04) a request never pre-empts a routine running at its own level
// (RULE_05) simultaneous requests of one level are resolved by polling the sources
// (RULE_06) polling order is a fixed source order, same pending set same winner
// (RULE_07) enable bit 7 gates every source; clear blocks all interrupts
// (RULE_08) enable bits 6..1: temp adc, timer2, uart, timer1, ext1, timer0
// (RULE_09) level bits 7..0: meter, temp, timer2, uart, timer1, ext1, timer0, ext0
// (RULE_10) secondary register bit 6 sets rtc level, bit 4 serial interface level
// (RULE_11) secondary bits 3..0 enable meter, rtc interval, supply monitor, serial interface
// (RULE_12) interrupts reach the core only while active; wakeup events stay separate
// (RULE_13) watchdog bit 3 clear gives reset on timeout, set gives interrupt
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_map.svh"

module irq_controller (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // special function register port of the core
  input wire irq_ctrl_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // interrupt sources
  input wire irq_ctrl_pkg::irq_src_t irq_src,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic wd_timeout,
  // core handshake
  input wire logic core_off_mode,
  input wire logic irq_ack,
  input wire logic irq_return,
  output irq_ctrl_pkg::irq_out_t irq_out,
  // watchdog control
  output logic wd_reset_req,
  output logic wd_restart,
  output logic wd_enable,
  output logic [3:0] wd_prescale
);

  irq_ctrl_pkg::ctl_state_t st_reg;
  irq_ctrl_pkg::ctl_state_t st_next;

  logic [`SRC_COUNT-1:0] raw_req;
  logic [`SRC_COUNT-1:0] src_on;
  logic [`SRC_COUNT-1:0] high_sel;
  logic [`SRC_COUNT-1:0] top_sel;
  logic [`SRC_COUNT-1:0] pending;
  logic arb_found;
  logic [3:0] arb_vector;
  irq_ctrl_pkg::irq_level_t arb_level;

  // rank of a level: 1 low, 2 high, 3 top
  function automatic logic [1:0] level_rank(input irq_ctrl_pkg::irq_level_t lvl);
    logic [1:0] r;
    r = 2'h1;
    case (lvl)
      irq_ctrl_pkg::level_low: r = 2'h1;
      irq_ctrl_pkg::level_high: r = 2'h2;
      irq_ctrl_pkg::level_top: r = 2'h3;
      default: r = 2'h1;
    endcase
    return r;
  endfunction : level_rank

  // rank of the highest routine in service, 0 when none runs
  function automatic logic [1:0] service_rank(input logic [2:0] ins);
    logic [1:0] r;
    r = 2'h0;
    if (ins[2]) begin
      r = 2'h3;
    end else if (ins[1]) begin
      r = 2'h2;
    end else if (ins[0]) begin
      r = 2'h1;
    end
    return r;
  endfunction : service_rank

  // collect requests in polling order; ext pins come through the synchroniser
  always_comb begin
    raw_req = '0;
    raw_req[`SRC_SUPPLY] = irq_src.supply_monitor;
    raw_req[`SRC_EXT0] = st_reg.ext_sync2[0];
    raw_req[`SRC_TIMER0] = irq_src.timer0;
    raw_req[`SRC_EXT1] = st_reg.ext_sync2[1];
    raw_req[`SRC_TIMER1] = irq_src.timer1;
    raw_req[`SRC_UART] = irq_src.uart;
    raw_req[`SRC_TIMER2] = irq_src.timer2;
    raw_req[`SRC_SERIAL_IF] = irq_src.serial_if;
    raw_req[`SRC_METER] = irq_src.meter;
    raw_req[`SRC_TEMP] = irq_src.temp_adc;
    raw_req[`SRC_RTC] = irq_src.rtc;
    raw_req[`SRC_WATCHDOG] = st_reg.wdcfg[`WD_STATUS_BIT] & st_reg.wdcfg[`WD_RESPONSE_BIT]; // [RULE_13]
  end

  // per-source enables
  always_comb begin
    src_on = '0;
    src_on[`SRC_SUPPLY] = st_reg.interrupt_enable_level_ext[`INTERRUPT_ENABLE_LEVEL_EXT_SUPPLY_ON_BIT]; // [RULE_11]
    src_on[`SRC_EXT0] = st_reg.ie[`IE_EXT0_BIT];
    src_on[`SRC_TIMER0] = st_reg.ie[`IE_TIMER0_BIT]; // [RULE_08]
    src_on[`SRC_EXT1] = st_reg.ie[`IE_EXT1_BIT]; // [RULE_08]
    src_on[`SRC_TIMER1] = st_reg.ie[`IE_TIMER1_BIT]; // [RULE_08]
    src_on[`SRC_UART] = st_reg.ie[`IE_UART_BIT]; // [RULE_08]
    src_on[`SRC_TIMER2] = st_reg.ie[`IE_TIMER2_BIT]; // [RULE_08]
    src_on[`SRC_SERIAL_IF] = st_reg.interrupt_enable_level_ext[`INTERRUPT_ENABLE_LEVEL_EXT_SIF_ON_BIT]; // [RULE_11]
    src_on[`SRC_METER] = st_reg.interrupt_enable_level_ext[`INTERRUPT_ENABLE_LEVEL_EXT_METER_ON_BIT]; // [RULE_11]
    src_on[`SRC_TEMP] = st_reg.ie[`IE_TEMP_BIT]; // [RULE_08]
    src_on[`SRC_RTC] = st_reg.interrupt_enable_level_ext[`INTERRUPT_ENABLE_LEVEL_EXT_RTC_ON_BIT]; // [RULE_11]
    src_on[`SRC_WATCHDOG] = 1'b1;
  end

  // per-source level selects
  always_comb begin
    high_sel = '0;
    top_sel = '0;
    top_sel[`SRC_SUPPLY] = 1'b1; // [RULE_02]
    high_sel[`SRC_EXT0] = st_reg.ip[`IP_EXT0_BIT]; // [RULE_09]
    high_sel[`SRC_TIMER0] = st_reg.ip[`IP_TIMER0_BIT]; // [RULE_09]
    high_sel[`SRC_EXT1] = st_reg.ip[`IP_EXT1_BIT]; // [RULE_09]
    high_sel[`SRC_TIMER1] = st_reg.ip[`IP_TIMER1_BIT]; // [RULE_09]
    high_sel[`SRC_UART] = st_reg.ip[`IP_UART_BIT]; // [RULE_09]
    high_sel[`SRC_TIMER2] = st_reg.ip[`IP_TIMER2_BIT]; // [RULE_09]
    high_sel[`SRC_SERIAL_IF] = st_reg.interrupt_enable_level_ext[`INTERRUPT_ENABLE_LEVEL_EXT_SIF_LEVEL_BIT]; // [RULE_10]
    high_sel[`SRC_METER] = st_reg.ip[`IP_METER_BIT]; // [RULE_09]
    high_sel[`SRC_TEMP] = st_reg.ip[`IP_TEMP_BIT]; // [RULE_09]
    high_sel[`SRC_RTC] = st_reg.interrupt_enable_level_ext[`INTERRUPT_ENABLE_LEVEL_EXT_RTC_LEVEL_BIT]; // [RULE_10]
    high_sel[`SRC_WATCHDOG] = 1'b1;
  end

  // global gate over all twelve sources
  always_comb begin
    pending = raw_req & src_on & {`SRC_COUNT{st_reg.ie[`IE_GATE_BIT]}}; // [RULE_01] [RULE_07]
  end

  irq_poll_arbiter u_arbiter (
    .pending(pending),
    .high_sel(high_sel),
    .top_sel(top_sel),
    .found(arb_found),
    .vector(arb_vector),
    .level(arb_level)
  );

  always_comb begin
    logic sfr_hit_wd;
    logic [2:0] ins;
    logic wd_fire;
    sfr_hit_wd = 1'b0;
    ins = 3'h0;
    wd_fire = 1'b0;
    st_next = st_reg;
    st_next.wd_reset_pulse = 1'b0;
    st_next.wd_restart_pulse = 1'b0;

    // two-stage synchroniser for the pin inputs
    st_next.ext_sync1 = {ext_irq1_pin, ext_irq0_pin};
    st_next.ext_sync2 = st_reg.ext_sync1;

    // register writes
    if (sfr_req.wr) begin
      st_next.wd_armed = 1'b0;
      case (sfr_req.addr)
        `SFR_IE_ADDR: st_next.ie = sfr_req.wdata;
        `SFR_INTERRUPT_ENABLE_LEVEL_EXT_ADDR: st_next.interrupt_enable_level_ext = sfr_req.wdata;
        `SFR_IP_ADDR: st_next.ip = sfr_req.wdata;
        `SFR_WDCFG_ADDR: begin
          sfr_hit_wd = 1'b1;
          if (st_reg.wd_armed) begin
            // protected write: only the one following the unlock lands
            st_next.wdcfg = sfr_req.wdata;
            st_next.wdcfg[`WD_WRITE_EN_BIT] = 1'b0;
            st_next.wd_restart_pulse = sfr_req.wdata[`WD_ENABLE_BIT];
          end else if (sfr_req.wdata[`WD_WRITE_EN_BIT]) begin
            st_next.wdcfg[`WD_WRITE_EN_BIT] = 1'b1;
            st_next.wd_armed = 1'b1;
          end
        end
        default: st_next.wd_armed = 1'b0;
      endcase
      if (!sfr_hit_wd) begin
        st_next.wdcfg[`WD_WRITE_EN_BIT] = 1'b0;
      end
    end

    // watchdog timeout: status set wins over a clearing write
    if (wd_timeout) begin
      st_next.wdcfg[`WD_STATUS_BIT] = 1'b1;
      if (!st_reg.wdcfg[`WD_RESPONSE_BIT]) begin // [RULE_13]
        wd_fire = 1'b1;
        st_next.wdcfg[`WD_ENABLE_BIT] = 1'b0;
      end
    end
    st_next.wd_reset_pulse = wd_fire; // [RULE_13]

    // register reads answer one cycle later
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        `SFR_IE_ADDR: st_next.rdata = st_reg.ie;
        `SFR_INTERRUPT_ENABLE_LEVEL_EXT_ADDR: st_next.rdata = st_reg.interrupt_enable_level_ext;
        `SFR_IP_ADDR: st_next.rdata = st_reg.ip;
        `SFR_WDCFG_ADDR: st_next.rdata = st_reg.wdcfg;
        default: st_next.rdata = `SFR_UNMAPPED_DATA;
      endcase
    end

    // service tracking: return pops the highest routine, then an acknowledge pushes
    ins = st_reg.in_service;
    if (irq_return) begin
      if (ins[2]) begin
        ins[2] = 1'b0;
      end else if (ins[1]) begin
        ins[1] = 1'b0;
      end else begin
        ins[0] = 1'b0;
      end
    end
    if (irq_ack && st_reg.out.req) begin
      case (st_reg.out.level)
        irq_ctrl_pkg::level_top: ins[2] = 1'b1;
        irq_ctrl_pkg::level_high: ins[1] = 1'b1;
        irq_ctrl_pkg::level_low: ins[0] = 1'b1;
        default: ins[0] = 1'b1;
      endcase
      // taking the supply monitor interrupt stops the watchdog
      if (st_reg.out.vector == 4'(`SRC_SUPPLY)) begin
        st_next.wdcfg[`WD_ENABLE_BIT] = 1'b0;
      end
    end
    st_next.in_service = ins;

    // request to the core only above the running level and only while it runs
    st_next.out.req = arb_found && !core_off_mode && // [RULE_12]
      (level_rank(arb_level) > service_rank(ins)); // [RULE_02] [RULE_03] [RULE_04]
    st_next.out.vector = arb_vector;
    st_next.out.level = arb_level;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg.ie <= `IE_RESET;
      st_reg.interrupt_enable_level_ext <= `INTERRUPT_ENABLE_LEVEL_EXT_RESET;
      st_reg.ip <= `IP_RESET;
      st_reg.wdcfg <= `WDCFG_RESET;
      st_reg.wd_armed <= 1'b0;
      st_reg.ext_sync1 <= 2'h0;
      st_reg.ext_sync2 <= 2'h0;
      st_reg.in_service <= 3'h0;
      st_reg.out <= '{req: 1'b0, vector: 4'h0, level: irq_ctrl_pkg::level_low};
      st_reg.rdata <= 8'h00;
      st_reg.wd_reset_pulse <= 1'b0;
      st_reg.wd_restart_pulse <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata = st_reg.rdata;
  assign irq_out = st_reg.out;
  assign wd_reset_req = st_reg.wd_reset_pulse;
  assign wd_restart = st_reg.wd_restart_pulse;
  assign wd_enable = st_reg.wdcfg[`WD_ENABLE_BIT];
  assign wd_prescale = st_reg.wdcfg[7:4];

endmodule : irq_controller
`default_nettype wire

/* test/irq_controller_monitor.sv */
// concurrent checks on the interrupt controller ports
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_map.svh"

module irq_controller_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register port
  input wire irq_ctrl_pkg::sfr_req_t sfr_req,
  // core handshake and watchdog
  input wire logic core_off_mode,
  input wire logic irq_ack,
  input wire irq_ctrl_pkg::irq_out_t irq_out,
  input wire logic wd_timeout,
  input wire logic wd_reset_req
);
  logic gate_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // shadow of the global gate, followed from register writes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gate_reg <= 1'b0;
    end else if (sfr_req.wr && sfr_req.addr == `SFR_IE_ADDR) begin
      gate_reg <= sfr_req.wdata[`IE_GATE_BIT];
    end
  end
  gate_closed_a: assert property (!gate_reg && !(sfr_req.wr && sfr_req.addr == `SFR_IE_ADDR) |=> !irq_out.req)
    else $error("request raised with the gate closed");
  core_off_a: assert property (core_off_mode |=> !irq_out.req)
    else $error("request raised while the core is off");
  ack_level_a: assert property (irq_ack && irq_out.req |=> (!irq_out.req || irq_out.level > $past(irq_out.level)))
    else $error("request after ack is not above the taken level");
  top_alone_a: assert property (irq_out.req && irq_out.vector != 4'h0 |-> irq_out.level != irq_ctrl_pkg::level_top)
    else $error("top level given to another source");
  top_vector_a: assert property (irq_out.req && irq_out.level == irq_ctrl_pkg::level_top |-> irq_out.vector == 4'h0)
    else $error("top level request not from supply monitor");
  vector_range_a: assert property (irq_out.req |-> irq_out.vector < 4'hC && irq_out.level != 2'h3)
    else $error("vector or level out of range");
  wd_level_a: assert property (irq_out.req && irq_out.vector == 4'hB |-> irq_out.level == irq_ctrl_pkg::level_high)
    else $error("watchdog request not at high level");
  wd_cause_a: assert property (wd_reset_req |-> $past(wd_timeout) || $past(wd_timeout, 2))
    else $error("reset request without timeout");
  wd_pulse_a: assert property (wd_reset_req |=> !wd_reset_req)
    else $error("reset request longer than one cycle");
endmodule : irq_controller_monitor

bind irq_controller irq_controller_monitor u_mon (
  .mclk, .sys_rst, .sfr_req, .core_off_mode, .irq_ack, .irq_out, .wd_timeout, .wd_reset_req
);
`default_nettype wire

/* test/core_model.sv */
// core stand-in: takes vectors and returns from routines
`timescale 1ns/100ps
`default_nettype none

module core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // controller side
  input wire irq_ctrl_pkg::irq_out_t irq_out,
  output logic irq_ack,
  output logic irq_return,
  // bench control
  input wire logic auto_ack,
  input wire logic ret_go
);
  logic go;
  logic take;
  int wait_cnt;
  initial begin
    irq_ack = 1'b0;
    irq_return = 1'b0;
    wait_cnt = 0;
  end
  // controls sampled at the edge, outputs changed just after it
  always @(posedge mclk) begin
    go = ret_go;
    take = auto_ack && !sys_rst;
    #2;
    irq_return = go;
    if (take && irq_out.req && !irq_ack && wait_cnt == 0) begin
      irq_ack = 1'b1;
      wait_cnt = $urandom_range(2);
    end else begin
      irq_ack = 1'b0;
      if (wait_cnt > 0) wait_cnt--;
    end
  end
endmodule : core_model
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_map.svh"

module testbench;
  logic mclk, sys_rst, p0, p1, wdt, off, auto_ack, ret_go, ack, ret, wrr, wen, wrs;
  int rs_cnt = 0;
  logic [7:0] rdata, ie, e2, ip;
  logic [3:0] wpre;
  logic [11:0] en, hi, pn;
  logic [6:0] got;
  int err_total, total_checks, n;
  irq_ctrl_pkg::sfr_req_t req;
  irq_ctrl_pkg::irq_src_t src;
  irq_ctrl_pkg::irq_out_t out;

  irq_controller u_dut (
    .mclk, .sys_rst, .sfr_req(req), .sfr_rdata(rdata), .irq_src(src), .ext_irq0_pin(p0), .ext_irq1_pin(p1),
    .wd_timeout(wdt), .core_off_mode(off), .irq_ack(ack), .irq_return(ret), .irq_out(out),
    .wd_reset_req(wrr), .wd_restart(wrs), .wd_enable(wen), .wd_prescale(wpre)
  );
  // counts restart pulses of the watchdog counter
  always @(posedge mclk) begin
    if (wrs === 1'b1) rs_cnt++;
  end
  core_model u_core (.mclk, .sys_rst, .irq_out(out), .irq_ack(ack), .irq_return(ret), .auto_ack, .ret_go);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic tick(int k = 1);
    repeat (k) @(posedge mclk);
    #2;
  endtask : tick
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    tick();
    req.wr = 1'b0;
    tick();
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    req.addr = a;
    req.rd = 1'b1;
    tick();
    req.rd = 1'b0;
    tick();
    chk("sfr_rdata", rdata, e);
  endtask : rd
  task automatic wait_ack(output logic [6:0] o);
    o = 7'h00;
    for (int i = 0; i < 20 && o == 7'h00; i++) begin
      @(posedge mclk);
      if (ack === 1'b1) o = out;
    end
    #2;
  endtask : wait_ack
  // highest level first, then lowest source index
  function automatic logic [6:0] exp_out(logic [11:0] p, logic [11:0] h);
    logic [6:0] r;
    r = 7'h00;
    for (int l = 0; l < 3; l++)
      for (int i = 11; i >= 0; i--)
        if (p[i] && (i == 0 ? 2 : int'(h[i])) == l) r = {1'b1, 4'(i), 2'(l)};
    return r;
  endfunction : exp_out
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end

  initial begin
    {sys_rst, p0, p1, wdt, off, auto_ack, ret_go} = 7'h40;
    req = '0;
    src = '0;
    err_total = 0;
    total_checks = 0;
    void'($urandom(97587));
    tick(5);
    sys_rst = 1'b0;
    rd(`SFR_IE_ADDR, 8'h00);
    rd(`SFR_INTERRUPT_ENABLE_LEVEL_EXT_ADDR, 8'hA0);
    rd(`SFR_IP_ADDR, 8'h00);
    rd(`SFR_WDCFG_ADDR, 8'h10);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    for (int k = 0; k < 40; k++) begin
      ie = $urandom;
      e2 = $urandom;
      ip = $urandom;
      src = 9'($urandom);
      {p0, p1} = 2'($urandom);
      off = ($urandom_range(7) == 0);
      if (k == 0) begin
        // every requesting source at low level: only polling decides
        {ie, e2, ip, src, p0, p1, off} = {8'hFF, 8'h0D, 8'h00, 9'h1FE, 3'h6};
      end
      wr(`SFR_IE_ADDR, ie);
      wr(`SFR_INTERRUPT_ENABLE_LEVEL_EXT_ADDR, e2);
      wr(`SFR_IP_ADDR, ip);
      tick(4);
      en = {1'b0, e2[2], ie[6], e2[3], e2[0], ie[5:0], e2[1]} & {12{ie[7]}};
      hi = {1'b1, e2[6], ip[6], ip[7], e2[4], ip[5:0], 1'b0};
      pn = {1'b0, src.rtc, src.temp_adc, src.meter, src.serial_if, src.timer2, src.uart, src.timer1, p1, src.timer0,
        p0, src.supply_monitor};
      // vector and level keep following the winner while the request is held back
      chk("irq_out", out, exp_out(pn & en, hi) & {~off, 6'h3F});
    end
    rd(`SFR_IE_ADDR, ie);
    rd(`SFR_INTERRUPT_ENABLE_LEVEL_EXT_ADDR, e2);
    rd(`SFR_IP_ADDR, ip);
    src = '0;
    {p0, p1, off} = 3'h0;
    wr(`SFR_IE_ADDR, 8'h9A);
    wr(`SFR_IP_ADDR, 8'h02);
    wr(`SFR_INTERRUPT_ENABLE_LEVEL_EXT_ADDR, 8'h02);
    auto_ack = 1'b1;
    src.uart = 1'b1;
    wait_ack(got);
    chk("low taken", got, 7'h54);
    src.timer1 = 1'b1;
    tick(3);
    chk("same level held", out, 7'h10);
    src.timer0 = 1'b1;
    wait_ack(got);
    chk("high over low", got, 7'h49);
    src.supply_monitor = 1'b1;
    wait_ack(got);
    chk("top over high", got, 7'h42);
    auto_ack = 1'b0;
    src.supply_monitor = 1'b0;
    src.timer0 = 1'b0;
    for (int i = 0; i < 3; i++) begin
      ret_go = 1'b1;
      tick();
      ret_go = 1'b0;
      tick(3);
      chk("after return", out, i == 2 ? 7'h50 : 7'h10);
    end
    src = '0;
    wr(`SFR_WDCFG_ADDR, 8'hFA);
    rd(`SFR_WDCFG_ADDR, 8'h10);
    wr(`SFR_WDCFG_ADDR, 8'h01);
    wr(`SFR_WDCFG_ADDR, 8'h0A);
    rd(`SFR_WDCFG_ADDR, 8'h0A);
    chk("wd_enable", {wpre, wen}, 5'h01);
    wdt = 1'b1;
    tick();
    wdt = 1'b0;
    tick(2);
    chk("wd irq", out, 7'h6D);
    rd(`SFR_WDCFG_ADDR, 8'h0E);
    wr(`SFR_WDCFG_ADDR, 8'h01);
    wr(`SFR_WDCFG_ADDR, 8'h02);
    tick(2);
    chk("wd irq cleared", out, 7'h00);
    wdt = 1'b1;
    tick();
    wdt = 1'b0;
    n = 0;
    repeat (3) begin
      n += (wrr === 1'b1);
      tick();
    end
    chk("wd reset pulses", n, 1);
    rd(`SFR_WDCFG_ADDR, 8'h04);
    chk("wd_restart pulses", rs_cnt, 2);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
